// file: hwpb_bus_master.sv
// bus master model that issues write and read bursts toward the bridge
`timescale 1ns/1ps
`default_nettype none
module hwpb_bus_master (
  input wire logic clk, // bus clock
  input wire logic devsel_n, // target claim, active low
  input wire logic trdy_n, // target ready, active low
  input wire logic stop_n, // target stop, active low
  output logic frame_n, // frame, active low
  output logic irdy_n, // initiator ready, active low
  output logic [31:0] ad_in, // address/data lines
  output logic [3:0] cbe_n // command / byte enables, active low
);
  logic stopped;
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    ad_in = 32'h0;
    cbe_n = 4'hF;
    stopped = 1'b0;
  end
  // word i carries d0 + i * 32'h01010101; gives up after six cycles without a claim
  task automatic burst(input logic [3:0] cmd, input logic [31:0] addr, input int n, input logic [31:0] d0,
                       input logic [3:0] be_n, output int got, output int w);
    got = 0;
    w = 0;
    stopped = 1'b0;
    @(posedge clk);
    frame_n <= 1'b0;
    ad_in <= addr;
    cbe_n <= cmd;
    @(posedge clk);
    frame_n <= (n == 1);
    irdy_n <= 1'b0;
    ad_in <= d0;
    cbe_n <= be_n;
    while (got < n && w < 2000) begin
      @(posedge clk);
      w++;
      if (!devsel_n && !trdy_n) begin
        got++;
        ad_in <= d0 + got * 32'h01010101;
        frame_n <= (got >= n - 1);
      end else if (!stop_n || (devsel_n && w > 5)) begin
        stopped = !stop_n;
        frame_n <= 1'b1;
        if (!frame_n) @(posedge clk);
        break;
      end
    end
    // released lines keep moving so a stale value is never mistaken for data
    irdy_n <= 1'b1;
    cbe_n <= ~cbe_n;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: hwpb_params.svh
// constants for the host write posting bridge
`ifndef HWPB_PARAMS_SVH
`define HWPB_PARAMS_SVH
`define HWPB_CMD_MEM_WR 4'h7
`define HWPB_CMD_MEM_WRI 4'hF
`define HWPB_CMD_MEM_RD 4'h6
`define HWPB_CMD_MEM_RDM 4'hC
`define HWPB_CMD_MEM_RDL 4'hE
`define HWPB_WIN_MSB 31
`define HWPB_WIN_LSB 24
`define HWPB_OFS_W 24
`define HWPB_REG_TOP 24'h3FFFFF
`define HWPB_LFB_TOP 24'h7FFFFF
`define HWPB_WORD_STEP 24'h000004
`define HWPB_MQ_MAX 16'hFFC0
`define HWPB_ENG_DIV 2
`define HWPB_WORD_W 62
`define HWPB_F_REGION 61:60
`define HWPB_F_BE 59:56
`define HWPB_F_OFS 55:32
`define HWPB_F_DATA 31:0
`endif

// file: hwpb_pkg.sv
// types for the host write posting bridge
`default_nettype none
package hwpb_pkg;
  typedef enum logic [3:0] {
    HWPB_S_IDLE = 4'b0001,
    HWPB_S_DATA = 4'b0010,
    HWPB_S_RETRY = 4'b0100,
    HWPB_S_TURN = 4'b1000
  } hwpb_state_t;
  typedef enum logic [1:0] {
    HWPB_RG_REG = 2'h0,
    HWPB_RG_LFB = 2'h1,
    HWPB_RG_TEX = 2'h2
  } hwpb_region_t;
endpackage
`default_nettype wire

// file: hwpb_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hwpb_skid #(
  parameter int W = 62
) (
  input wire logic clk, // clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // spare entry free
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data // word out
);
  logic spare_v_r;
  logic [W-1:0] spare_r;
  logic in_fire;
  assign in_ready = !spare_v_r;
  assign in_fire = in_valid && !spare_v_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      spare_v_r <= 1'b0;
      out_data <= '0;
      spare_r <= '0;
    end else if (!out_valid || out_ready) begin
      if (spare_v_r) begin
        out_data <= spare_r;
        out_valid <= 1'b1;
        spare_v_r <= 1'b0;
      end else begin
        out_valid <= in_fire;
        if (in_fire) begin
          out_data <= in_data;
        end
      end
    end else if (in_fire) begin
      // consumer stalled: park the word instead of losing it
      spare_r <= in_data;
      spare_v_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hwpb_top.sv
// bus target front end that posts host writes toward the graphics engine
//
// Contract
// - target only, never master; bursts accepted
// - writes taken with zero wait states; trdy held off while the 64-entry posting queue is full
// - writes posted into 64-entry queue
// - queue decouples bus and engine rates
// - optional memory queue extends posting depth
// - claim 16 MB memory window, never I/O
// - decode register, frame buffer, texture regions
// - registers at zero, frame buffer 4-8 MB
// - address equals window base plus offset
// - frame buffer writes forwarded with format intact
// - texture writes forwarded to texture memory
`timescale 1ns/1ps
`default_nettype none
`include "hwpb_params.svh"
module hwpb_top #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int ENG_DIV = `HWPB_ENG_DIV
) (
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic frame_n, // bus frame, active low
  input wire logic irdy_n, // initiator ready, active low
  input wire logic [31:0] ad_in, // address/data lines
  input wire logic [3:0] cbe_n, // command / byte enables, active low
  input wire logic [7:0] mem_base, // window base from config space
  output logic devsel_n, // device select, active low
  output logic devsel_oe, // drive enable for devsel
  output logic trdy_n, // target ready, active low
  output logic trdy_oe, // drive enable for trdy
  output logic stop_n, // stop, active low
  output logic stop_oe, // drive enable for stop
  input wire logic mq_en, // memory queue enable
  input wire logic [15:0] mq_depth, // memory queue depth in words
  output logic mq_wr_valid, // word to off-screen memory
  input wire logic mq_wr_ready, // memory takes word
  output logic [61:0] mq_wr_data, // spilled word
  input wire logic mq_rd_valid, // word back from memory
  output logic mq_rd_ready, // bridge takes word back
  input wire logic [61:0] mq_rd_data, // refilled word
  output logic eng_stb, // engine rate enable pulse
  output logic eng_valid, // posted write available
  input wire logic eng_ready, // engine accepts on strobe
  output hwpb_pkg::hwpb_region_t eng_region, // target region
  output logic [23:0] eng_addr, // window offset
  output logic [3:0] eng_be_n, // byte enables, active low
  output logic [31:0] eng_data // write data
);
  import hwpb_pkg::*;

  function automatic hwpb_region_t region_of(input logic [23:0] ofs);
    if (ofs <= `HWPB_REG_TOP) begin
      region_of = HWPB_RG_REG;
    end else if (ofs <= `HWPB_LFB_TOP) begin
      region_of = HWPB_RG_LFB;
    end else begin
      region_of = HWPB_RG_TEX;
    end
  endfunction

  hwpb_state_t st_r;
  logic frame_q_r;
  logic [23:0] addr_r;
  logic [61:0] fifo_mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic [15:0] mq_cnt_r;
  logic [15:0] mq_lim;
  logic [7:0] div_r;
  logic addr_ph, win_hit, wr_cmd, rd_cmd, xfer, pop, to_mq, mq_busy;
  logic sk_rdy, sk_in_v, sk_fire, mq_rd_fire, mq_wr_fire, mq_room;
  logic [61:0] sk_in_d;
  logic [61:0] sk_out_d;

  assign addr_ph = !frame_n && frame_q_r;
  assign win_hit = ad_in[`HWPB_WIN_MSB:`HWPB_WIN_LSB] == mem_base;
  // memory commands only; I/O and config cycles never match
  assign wr_cmd = cbe_n == `HWPB_CMD_MEM_WR || cbe_n == `HWPB_CMD_MEM_WRI;
  assign rd_cmd = cbe_n == `HWPB_CMD_MEM_RD || cbe_n == `HWPB_CMD_MEM_RDM || cbe_n == `HWPB_CMD_MEM_RDL;
  assign xfer = st_r == HWPB_S_DATA && !irdy_n && !trdy_n;

  // drain routing: once anything sits in memory, everything follows it there to keep order
  assign mq_busy = mq_cnt_r != 16'h0000 || mq_wr_valid;
  assign mq_lim = mq_depth > `HWPB_MQ_MAX ? `HWPB_MQ_MAX : mq_depth;
  assign mq_room = (mq_cnt_r + {15'h0000, mq_wr_valid}) < mq_lim;
  assign to_mq = mq_busy || (mq_en && !sk_rdy);
  assign mq_wr_fire = mq_wr_valid && mq_wr_ready;
  assign pop = count_r != '0 && (to_mq ? (mq_room && (!mq_wr_valid || mq_wr_ready)) : sk_rdy);
  assign mq_rd_fire = mq_rd_valid && mq_rd_ready;
  assign sk_in_v = mq_busy ? mq_rd_fire : (pop && !to_mq);
  assign sk_in_d = mq_busy ? mq_rd_data : fifo_mem[rd_ptr_r];
  assign sk_fire = sk_in_v && sk_rdy;
  assign count_nxt = count_r + {{AW{1'b0}}, xfer} - {{AW{1'b0}}, pop};

  // bus target state machine; it never drives frame, irdy or ad
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= HWPB_S_IDLE;
      frame_q_r <= 1'b1;
      addr_r <= '0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      stop_n <= 1'b1;
      devsel_oe <= 1'b0;
      trdy_oe <= 1'b0;
      stop_oe <= 1'b0;
    end else begin
      frame_q_r <= frame_n;
      case (st_r)
        HWPB_S_IDLE: begin
          devsel_oe <= 1'b0;
          trdy_oe <= 1'b0;
          stop_oe <= 1'b0;
          if (addr_ph && win_hit && wr_cmd) begin
            st_r <= HWPB_S_DATA;
            addr_r <= ad_in[`HWPB_OFS_W-1:0];
            devsel_n <= 1'b0;
            trdy_n <= count_nxt >= DEPTH[AW:0];
            stop_n <= 1'b1;
            devsel_oe <= 1'b1;
            trdy_oe <= 1'b1;
            stop_oe <= 1'b1;
          end else if (addr_ph && win_hit && rd_cmd) begin
            // reads are not served by this bridge; the master is told to retry
            st_r <= HWPB_S_RETRY;
            devsel_n <= 1'b0;
            trdy_n <= 1'b1;
            stop_n <= 1'b0;
            devsel_oe <= 1'b1;
            trdy_oe <= 1'b1;
            stop_oe <= 1'b1;
          end
        end
        HWPB_S_DATA: begin
          if (xfer) begin
            addr_r <= addr_r + `HWPB_WORD_STEP;
          end
          if (xfer && frame_n) begin
            st_r <= HWPB_S_TURN;
            devsel_n <= 1'b1;
            trdy_n <= 1'b1;
          end else begin
            trdy_n <= count_nxt >= DEPTH[AW:0];
          end
        end
        HWPB_S_RETRY: begin
          if (frame_n) begin
            st_r <= HWPB_S_TURN;
            devsel_n <= 1'b1;
            stop_n <= 1'b1;
          end
        end
        HWPB_S_TURN: begin
          // one cycle of driving high before release
          st_r <= HWPB_S_IDLE;
          devsel_oe <= 1'b0;
          trdy_oe <= 1'b0;
          stop_oe <= 1'b0;
        end
        default: begin
          st_r <= HWPB_S_IDLE;
        end
      endcase
    end
  end

  // posting queue storage
  always_ff @(posedge clk) begin
    if (xfer) begin
      fifo_mem[wr_ptr_r] <= {region_of(addr_r), cbe_n, addr_r, ad_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(xfer);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
    end
  end

  // memory queue: spill port, occupancy and refill pacing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mq_wr_valid <= 1'b0;
      mq_wr_data <= '0;
      mq_cnt_r <= '0;
      mq_rd_ready <= 1'b0;
    end else begin
      if (pop && to_mq) begin
        mq_wr_valid <= 1'b1;
        mq_wr_data <= fifo_mem[rd_ptr_r];
      end else if (mq_wr_fire) begin
        mq_wr_valid <= 1'b0;
      end
      mq_cnt_r <= mq_cnt_r + 16'(mq_wr_fire) - 16'(mq_rd_fire);
      // refill at most every other cycle so a word never lands on a full buffer
      mq_rd_ready <= mq_cnt_r != 16'h0000 && sk_rdy && !sk_fire && !mq_rd_fire;
    end
  end

  // engine rate enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_r <= '0;
      eng_stb <= 1'b0;
    end else begin
      div_r <= div_r == 8'(ENG_DIV - 1) ? 8'h00 : div_r + 8'h01;
      eng_stb <= div_r == 8'(ENG_DIV - 1);
    end
  end

  hwpb_skid #(.W(`HWPB_WORD_W)) u_skid (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(sk_in_v),
    .in_ready(sk_rdy),
    .in_data(sk_in_d),
    .out_valid(eng_valid),
    .out_ready(eng_ready && eng_stb),
    .out_data(sk_out_d)
  );
  assign eng_region = hwpb_region_t'(sk_out_d[`HWPB_F_REGION]);
  assign eng_be_n = sk_out_d[`HWPB_F_BE];
  assign eng_addr = sk_out_d[`HWPB_F_OFS];
  assign eng_data = sk_out_d[`HWPB_F_DATA];

  property p_no_claim_miss;
    @(posedge clk) disable iff (!reset_n)
    (st_r == HWPB_S_IDLE && addr_ph && !(win_hit && (wr_cmd || rd_cmd))) |=> !devsel_oe;
  endproperty
  a_no_claim_miss: assert property (p_no_claim_miss) else $error("claimed outside window");
  property p_zero_wait;
    @(posedge clk) disable iff (!reset_n)
    (st_r == HWPB_S_IDLE && addr_ph && win_hit && wr_cmd && count_r < 7'(DEPTH - 1)) |=> !trdy_n && !devsel_n;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("write not taken at once");
  property p_post_count;
    @(posedge clk) disable iff (!reset_n)
    (xfer && !pop) |=> count_r == $past(count_r) + 7'h01;
  endproperty
  a_post_count: assert property (p_post_count) else $error("posted write not counted");
  property p_full_stall;
    @(posedge clk) disable iff (!reset_n)
    count_r == DEPTH[AW:0] |-> trdy_n;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("ready while queue full");
  property p_bound;
    @(posedge clk) disable iff (!reset_n)
    count_r <= DEPTH[AW:0];
  endproperty
  a_bound: assert property (p_bound) else $error("queue overflow");
  property p_region;
    @(posedge clk) disable iff (!reset_n)
    eng_valid |-> eng_region == region_of(eng_addr);
  endproperty
  a_region: assert property (p_region) else $error("region tag wrong");
  property p_mq_lim;
    @(posedge clk) disable iff (!reset_n)
    $rose(mq_wr_valid) |-> $past(mq_cnt_r) < $past(mq_lim);
  endproperty
  a_mq_lim: assert property (p_mq_lim) else $error("memory queue past depth");
  property p_eng_hold;
    @(posedge clk) disable iff (!reset_n)
    (eng_valid && !(eng_ready && eng_stb)) |=> eng_valid && $stable(eng_data) && $stable(eng_addr);
  endproperty
  a_eng_hold: assert property (p_eng_hold) else $error("engine word changed while stalled");
  property p_burst_step;
    @(posedge clk) disable iff (!reset_n)
    (xfer && !frame_n) |=> addr_r == $past(addr_r) + `HWPB_WORD_STEP;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst address not stepped");
  c_burst: cover property (@(posedge clk) xfer ##1 xfer ##1 xfer);
  c_retry: cover property (@(posedge clk) st_r == HWPB_S_RETRY);
  c_full: cover property (@(posedge clk) count_r == DEPTH[AW:0]);
  c_spill: cover property (@(posedge clk) mq_wr_fire ##[1:50] mq_rd_fire);
endmodule
`default_nettype wire

// file: tb_host_write_posting_bridge.sv
// self-checking bench for the host write posting bridge
`timescale 1ns/1ps
`default_nettype none
module tb_host_write_posting_bridge;
  import hwpb_pkg::*;
  localparam logic [7:0] BASE = 8'h5C;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic frame_n, irdy_n, devsel_n, devsel_oe, trdy_n, trdy_oe, stop_n, stop_oe;
  logic [31:0] ad_in, eng_data;
  logic [3:0] cbe_n, eng_be_n;
  logic mq_en, mq_wr_valid, mq_rd_ready, eng_stb, eng_valid, hold;
  logic mq_wr_ready = 1'b1;
  logic mq_rd_valid = 1'b0;
  logic eng_ready = 1'b0;
  logic [15:0] mq_depth;
  logic [61:0] mq_wr_data;
  logic [61:0] mq_rd_data = 62'h0;
  hwpb_region_t eng_region;
  logic [23:0] eng_addr;
  logic [61:0] exp_q[$], mem_q[$];
  logic [3:0] rd_cmds[3] = '{4'h6, 4'hC, 4'hE};
  logic [23:0] ofs_tab[6] = '{24'h000010, 24'h3FFFF8, 24'h4000A0, 24'h7FFFF8, 24'h800000, 24'hFFFFF0};
  int n_fail = 0, n_compared = 0, w;
  integer seed = 32'h3AD7;
  always #12.5 clk = ~clk;
  hwpb_bus_master bm (.clk(clk), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n), .frame_n(frame_n),
    .irdy_n(irdy_n), .ad_in(ad_in), .cbe_n(cbe_n));
  hwpb_top dut (.clk(clk), .reset_n(reset_n), .frame_n(frame_n), .irdy_n(irdy_n), .ad_in(ad_in), .cbe_n(cbe_n),
    .mem_base(BASE), .devsel_n(devsel_n), .devsel_oe(devsel_oe), .trdy_n(trdy_n), .trdy_oe(trdy_oe),
    .stop_n(stop_n), .stop_oe(stop_oe), .mq_en(mq_en), .mq_depth(mq_depth), .mq_wr_valid(mq_wr_valid),
    .mq_wr_ready(mq_wr_ready), .mq_wr_data(mq_wr_data), .mq_rd_valid(mq_rd_valid), .mq_rd_ready(mq_rd_ready),
    .mq_rd_data(mq_rd_data), .eng_stb(eng_stb), .eng_valid(eng_valid), .eng_ready(eng_ready),
    .eng_region(eng_region), .eng_addr(eng_addr), .eng_be_n(eng_be_n), .eng_data(eng_data));
  function automatic hwpb_region_t region_of(input logic [23:0] ofs);
    if (ofs <= 24'h3FFFFF) return HWPB_RG_REG;
    if (ofs <= 24'h7FFFFF) return HWPB_RG_LFB;
    return HWPB_RG_TEX;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] cmd, input logic [23:0] ofs, input int n, input logic [3:0] be, input bit zw,
                    output int wt);
    logic [31:0] d0;
    logic [23:0] a;
    int got;
    d0 = $random(seed);
    for (int i = 0; i < n; i++) begin
      a = ofs + 24'(4 * i);
      exp_q.push_back({region_of(a), be, a, d0 + 32'(i) * 32'h01010101});
    end
    bm.burst(cmd, {BASE, ofs}, n, d0, be, got, wt);
    check(got, n);
    if (zw) check(wt, n);
  endtask
  task automatic nohit(input logic [3:0] cmd, input logic [7:0] base, input logic exp_stop);
    int got, wt;
    bm.burst(cmd, {base, 24'h000100}, 2, 32'h0, 4'h0, got, wt);
    check(got, 0);
    check(bm.stopped, exp_stop);
  endtask
  task automatic drain;
    for (int k = 0; k < 4000 && exp_q.size() != 0; k++) @(posedge clk);
  endtask
  // engine side: stalls at random, or fully while hold is set
  always @(posedge clk) begin
    eng_ready <= !hold && (($random(seed) & 32'h3) != 0);
    if (reset_n && eng_valid && eng_ready && eng_stb)
      check({eng_region, eng_be_n, eng_addr, eng_data}, exp_q.size() ? exp_q.pop_front() : 62'h0);
  end
  // off-screen memory hands spilled words back in order
  always @(posedge clk) begin
    // the spill port stalls now and then, so the bridge must hold its word
    mq_wr_ready <= ($random(seed) & 32'h7) != 0;
    if (mq_wr_valid && mq_wr_ready) mem_q.push_back(mq_wr_data);
    if (mq_rd_valid && mq_rd_ready) void'(mem_q.pop_front());
    mq_rd_valid <= (mem_q.size() != 0);
    mq_rd_data <= (mem_q.size() != 0) ? mem_q[0] : ~mq_rd_data;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    mq_en = 1'b0;
    mq_depth = 16'h0000;
    hold = 1'b0;
    repeat (20) @(posedge clk);
    check({devsel_oe, trdy_oe, stop_oe, eng_valid, mq_wr_valid}, 5'h00);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (ofs_tab[k]) begin
      drain;
      wr(k[0] ? 4'hF : 4'h7, ofs_tab[k], (k == 0) ? 1 : 4, 4'($random(seed)), 1'b1, w);
    end
    foreach (rd_cmds[c]) nohit(rd_cmds[c], BASE, 1'b1);
    nohit(4'h2, BASE, 1'b0);
    nohit(4'hA, BASE, 1'b0);
    nohit(4'h7, BASE ^ 8'h01, 1'b0);
    drain;
    hold <= 1'b1;
    fork
      begin
        repeat (300) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    wr(4'h7, 24'h400000, 80, 4'h0, 1'b0, w);
    check(w > 80, 1'b1);
    drain;
    mq_en <= 1'b1;
    mq_depth <= 16'h0100;
    hold <= 1'b1;
    wr(4'h7, 24'h800400, 200, 4'h3, 1'b1, w);
    hold <= 1'b0;
    drain;
    // shallow memory queue: posting must stall once both queues are full
    mq_depth <= 16'h0010;
    hold <= 1'b1;
    fork
      begin
        repeat (300) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    wr(4'h7, 24'h000200, 100, 4'h5, 1'b0, w);
    check(w > 100, 1'b1);
    drain;
    check(exp_q.size(), 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
